// file: dv/scs_board_model.sv
`timescale 1ns/100ps
// board side: slow synth clocks in, status lines out with a pull-down
module scs_board_model (
  input wire logic i_clk,
  input wire logic i_pin_a,
  input wire logic i_pin_a_oe_n,
  input wire logic i_pin_b,
  input wire logic i_pin_b_oe_n,
  output logic o_synth_a_clk,
  output logic o_synth_b_clk,
  output logic o_line_a,
  output logic o_line_b
);
  // periods of 8 and 10 cycles keep both clocks well under the sampler limit
  logic [2:0] cnt_a = 3'h0;
  logic [3:0] cnt_b = 4'h0;
  always @(posedge i_clk) begin
    cnt_a <= cnt_a + 3'h1;
    cnt_b <= (cnt_b == 4'h9) ? 4'h0 : cnt_b + 4'h1;
  end
  // one driver per clock: each is decoded from its own counter
  assign o_synth_a_clk = cnt_a[2];
  assign o_synth_b_clk = (cnt_b >= 4'h5);
  // a released line falls to the board pull-down
  assign o_line_a = i_pin_a_oe_n ? 1'b0 : i_pin_a;
  assign o_line_b = i_pin_b_oe_n ? 1'b0 : i_pin_b;
endmodule : scs_board_model

// file: dv/tb_top.sv
`timescale 1ns/100ps
`include "scs_defs.svh"
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [`SCS_ADDR_W-1:0] adr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'h0;
  logic st_a = 1'b0;
  logic st_b = 1'b0;
  logic [31:0] rdat;
  logic wreq, pa, pa_oe_n, pb, pb_oe_n, pre_a, pre_b, sa, sb, line_a, line_b;
  logic [3:0] obs;
  logic [3:0] obs_q = 4'h0;
  int cyc = 0;
  int last_r [4] = '{0, 0, 0, 0};
  int per_q [4] = '{0, 0, 0, 0};
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] d;
  logic [7:0] codes [3] = '{8'h01, 8'h05, 8'h07};
  int rat [3] = '{6, 6, 8};
  always #50 i_clk = ~i_clk;
  scs_status_clock_select u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_synth_a_clk(sa), .i_synth_b_clk(sb), .i_status_a(st_a), .i_status_b(st_b),
    .o_status_pin_a(pa), .o_status_pin_a_oe_n(pa_oe_n), .o_status_pin_b(pb), .o_status_pin_b_oe_n(pb_oe_n),
    .o_prescale_a_clk(pre_a), .o_prescale_b_clk(pre_b));
  scs_board_model u_board (.i_clk(i_clk), .i_pin_a(pa), .i_pin_a_oe_n(pa_oe_n), .i_pin_b(pb),
    .i_pin_b_oe_n(pb_oe_n), .o_synth_a_clk(sa), .o_synth_b_clk(sb), .o_line_a(line_a), .o_line_b(line_b));
  assign obs = {line_b, line_a, pre_b, pre_a};
  // period between rising edges, in i_clk cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    obs_q <= obs;
    for (int k = 0; k < 4; k++) begin
      if (obs[k] === 1'b1 && obs_q[k] === 1'b0) begin
        per_q[k] <= cyc - last_r[k];
        last_r[k] <= cyc;
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] v, input logic [3:0] b,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    rd_en <= !w;
    wr_en <= w;
    wdat <= v;
    be <= b;
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_fail++;
      wrap_up();
    end
    r = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 4'h1, d);
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h1, d);
    chk(d, e);
  endtask : rdc
  // long enough for several periods of the slowest clock under test
  task automatic meas(input int e0, input int e1, input int e2, input int e3);
    repeat (1200) @(posedge i_clk);
    chk(per_q[0], e0);
    chk(per_q[1], e1);
    chk(per_q[2], e2);
    chk(per_q[3], e3);
  endtask : meas
  task automatic still(input int k, input logic v);
    int f;
    f = 0;
    repeat (300) begin
      @(posedge i_clk);
      if (obs[k] !== v) f++;
    end
    chk(f, 0);
  endtask : still
  task automatic rst();
    i_rst_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask : rst
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #3000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    rst();
    st_a <= 1'b1;
    rdc(10'h02d, 32'h0a);
    rdc(10'h02e, 32'h0);
    rdc(10'h02f, 32'h0);
    repeat (5) @(posedge i_clk);
    chk({pb_oe_n, pa_oe_n, line_b, line_a}, 32'h1);
    rdc(10'h030, 32'h1);
    still(0, 1'b0);
    $display("test reset done");
    wr(10'h040, 32'hff);
    rdc(10'h040, 32'h0);
    bus(1'b1, 10'h02d, 32'hff, 4'h0, d);
    rdc(10'h02d, 32'h0a);
    $display("test refusal done");
    wr(10'h02d, 32'h94);
    rdc(10'h02d, 32'h94);
    wr(10'h02f, 32'h06);
    for (int i = 0; i < 3; i++) begin
      wr(10'h02e, {24'h0, codes[i]});
      rdc(10'h02e, {24'h0, codes[i]});
      meas(32, 50, 32 * rat[i], 350);
    end
    wr(10'h02d, 32'h64);
    meas(40, 40, 320, 280);
    wr(10'h02d, 32'h61);
    meas(40, 40, 280, 320);
    $display("test routing done");
    wr(10'h02d, 32'hcc);
    repeat (5) @(posedge i_clk);
    chk(pb_oe_n, 32'h1);
    still(1, 1'b0);
    still(0, 1'b0);
    still(2, 1'b0);
    wr(10'h02d, 32'h67);
    wr(10'h02f, 32'h00);
    repeat (5) @(posedge i_clk);
    chk(pa_oe_n, 32'h1);
    still(3, 1'b0);
    $display("test disable done");
    rst();
    rdc(10'h02d, 32'h0a);
    rdc(10'h02e, 32'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb_top

// file: logic/scs_defs.svh
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
// register byte addresses (printed offsets are not all word multiples)
`define SCS_IDX_ROUTE_CTRL 8'h2d
`define SCS_IDX_DIV_A 8'h2e
`define SCS_IDX_DIV_B 8'h2f
`define SCS_IDX_STATUS_IN 8'h30
`define SCS_ADDR_W 10
`define SCS_RESET_ROUTE_CTRL 8'ha
`define SCS_RESET_DIV 8'h00
`define SCS_F_PRE_B_HI 7
`define SCS_F_PRE_B_LO 6
`define SCS_F_PRE_A_HI 5
`define SCS_F_PRE_A_LO 4
`define SCS_F_PIN_B_HI 3
`define SCS_F_PIN_B_LO 2
`define SCS_F_PIN_A_HI 1
`define SCS_F_PIN_A_LO 0
`define SCS_PRE_RATIO_LO 8'd4
`define SCS_PRE_RATIO_HI 8'd5
`define SCS_DIV_MIN_RATIO 9'd6
`define SCS_DIV_MIN_CODE 8'd5
`endif

// file: logic/scs_divider.sv
`timescale 1ns/100ps
`include "scs_defs.svh"
// counts enable ticks; emits a one-cycle tick and a toggling clock every ratio ticks
module scs_divider (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic i_tick,
  input wire logic [8:0] i_ratio,
  output logic o_tick,
  output logic o_clk
);
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic next_tick;
  logic next_clk;
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    next_clk = o_clk;
    if (!i_en) begin
      // disabled path held static low
      next_cnt = 9'd0;
      next_clk = 1'b0;
    end else if (i_tick) begin
      if (cnt >= i_ratio - 9'd1) begin
        next_cnt = 9'd0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 9'd1;
      end
      if (cnt == 9'd0 || cnt == (i_ratio >> 1)) begin
        next_clk = (cnt == 9'd0);
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= 9'd0;
      o_tick <= 1'b0;
      o_clk <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_tick <= next_tick;
      o_clk <= next_clk;
    end
  end
endmodule : scs_divider

// file: logic/scs_pkg.sv
`include "scs_defs.svh"
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_PIN_DIV_A = 2'h0,
    SCS_PIN_DIV_B = 2'h1,
    SCS_PIN_STATUS = 2'h2,
    SCS_PIN_OFF = 2'h3
  } scs_pin_sel_t;
  typedef enum logic [1:0] {
    SCS_PRE_OFF = 2'h0,
    SCS_PRE_DIV4 = 2'h1,
    SCS_PRE_DIV5 = 2'h2,
    SCS_PRE_RSVD = 2'h3
  } scs_pre_sel_t;
  typedef struct packed {
    scs_pre_sel_t pre_b;
    scs_pre_sel_t pre_a;
    scs_pin_sel_t pin_b;
    scs_pin_sel_t pin_a;
  } scs_route_t;
  typedef struct packed {
    logic [`SCS_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } scs_av_req_t;
endpackage : scs_pkg

// file: logic/scs_status_clock_select.sv
`timescale 1ns/100ps
`include "scs_defs.svh"
// What this block does
// - each status pin may carry clock from output divider a or b per its selection
// - output dividers are fed from synth a or synth b pre-divided clock
// - bits 7:6 pick synth b pre-divider: off, by 4, by 5, reserved
// - bits 5:4 pick synth a pre-divider: off, by 4, by 5, reserved
// - bits 3:2 pick pin b source; reset normal status
// - bits 1:0 pick pin a source; reset normal status
// - divider code 0 off, 1..5 divide by 6, else code plus one
module scs_status_clock_select (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [`SCS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_synth_a_clk,
  input wire logic i_synth_b_clk,
  input wire logic i_status_a,
  input wire logic i_status_b,
  output logic o_status_pin_a,
  output logic o_status_pin_a_oe_n,
  output logic o_status_pin_b,
  output logic o_status_pin_b_oe_n,
  output logic o_prescale_a_clk,
  output logic o_prescale_b_clk
);
  scs_pkg::scs_route_t route;
  scs_pkg::scs_route_t next_route;
  logic [7:0] div_a_code;
  logic [7:0] div_b_code;
  logic [7:0] next_div_a_code;
  logic [7:0] next_div_b_code;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  scs_pkg::scs_av_req_t req;
  logic hit;
  logic commit;
  logic stat_a;
  logic stat_b;

  // one cycle of wait per access: answer registered the edge after the request
  function automatic logic [31:0] merge(input logic [7:0] old, input logic [31:0] wd, input logic be0);
    merge = {24'h0, be0 ? wd[7:0] : old};
  endfunction : merge

  function automatic logic [8:0] pre_ratio(input scs_pkg::scs_pre_sel_t s);
    unique case (s)
      scs_pkg::SCS_PRE_DIV4: pre_ratio = {1'b0, `SCS_PRE_RATIO_LO};
      scs_pkg::SCS_PRE_DIV5: pre_ratio = {1'b0, `SCS_PRE_RATIO_HI};
      default: pre_ratio = 9'd0;
    endcase
  endfunction : pre_ratio

  function automatic logic [8:0] div_ratio(input logic [7:0] code);
    if (code <= `SCS_DIV_MIN_CODE) begin
      div_ratio = `SCS_DIV_MIN_RATIO;
    end else begin
      div_ratio = {1'b0, code} + 9'd1;
    end
  endfunction : div_ratio

  function automatic logic pre_on(input scs_pkg::scs_pre_sel_t s);
    pre_on = (s == scs_pkg::SCS_PRE_DIV4) || (s == scs_pkg::SCS_PRE_DIV5);
  endfunction : pre_on

  assign req = '{address: i_avs_address, read: i_avs_read, write: i_avs_write, writedata: i_avs_writedata};
  assign hit = o_avs_waitrequest && (req.read || req.write);
  assign commit = !o_avs_waitrequest && req.write;

  always_comb begin
    next_route = route;
    next_div_a_code = div_a_code;
    next_div_b_code = div_b_code;
    next_readdata = o_avs_readdata;
    next_waitrequest = 1'b1;
    if (hit) begin
      next_waitrequest = 1'b0;
      unique case (req.address)
        {2'h0, `SCS_IDX_ROUTE_CTRL}: begin
          next_readdata = {24'h0, route};
        end
        {2'h0, `SCS_IDX_DIV_A}: begin
          next_readdata = {24'h0, div_a_code};
        end
        {2'h0, `SCS_IDX_DIV_B}: begin
          next_readdata = {24'h0, div_b_code};
        end
        {2'h0, `SCS_IDX_STATUS_IN}: begin
          next_readdata = {30'h0, stat_b, stat_a};
        end
        default: begin
          next_readdata = 32'h0;
        end
      endcase
    end
    // write lands on the edge where the master sees waitrequest low, never earlier
    if (commit) begin
      unique case (req.address)
        {2'h0, `SCS_IDX_ROUTE_CTRL}: begin
          next_route = scs_pkg::scs_route_t'(
            8'(merge(route, req.writedata, i_avs_byteenable[0])));
        end
        {2'h0, `SCS_IDX_DIV_A}: begin
          next_div_a_code = 8'(merge(div_a_code, req.writedata, i_avs_byteenable[0]));
        end
        {2'h0, `SCS_IDX_DIV_B}: begin
          next_div_b_code = 8'(merge(div_b_code, req.writedata, i_avs_byteenable[0]));
        end
        default: begin
          // unmapped or read-only: write dropped
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      route <= scs_pkg::scs_route_t'(`SCS_RESET_ROUTE_CTRL);
      div_a_code <= `SCS_RESET_DIV;
      div_b_code <= `SCS_RESET_DIV;
      o_avs_readdata <= 32'h0;
      o_avs_waitrequest <= 1'b1;
    end else begin
      route <= next_route;
      div_a_code <= next_div_a_code;
      div_b_code <= next_div_b_code;
      o_avs_readdata <= next_readdata;
      o_avs_waitrequest <= next_waitrequest;
    end
  end

  // synth clocks and status levels come from outside: two flops each
  logic [1:0] sync_sa;
  logic [1:0] sync_sb;
  logic [1:0] sync_st_a;
  logic [1:0] sync_st_b;
  logic sa_q;
  logic sb_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_sa <= 2'b00;
      sync_sb <= 2'b00;
      sync_st_a <= 2'b00;
      sync_st_b <= 2'b00;
      sa_q <= 1'b0;
      sb_q <= 1'b0;
    end else begin
      sync_sa <= {sync_sa[0], i_synth_a_clk};
      sync_sb <= {sync_sb[0], i_synth_b_clk};
      sync_st_a <= {sync_st_a[0], i_status_a};
      sync_st_b <= {sync_st_b[0], i_status_b};
      sa_q <= sync_sa[1];
      sb_q <= sync_sb[1];
    end
  end
  assign stat_a = sync_st_a[1];
  assign stat_b = sync_st_b[1];

  // rising edges of the sampled synth clocks act as count enables
  logic edge_a;
  logic edge_b;
  assign edge_a = sync_sa[1] && !sa_q;
  assign edge_b = sync_sb[1] && !sb_q;

  logic pre_a_tick;
  logic pre_b_tick;
  logic pre_a_clk;
  logic pre_b_clk;
  logic div_a_tick;
  logic div_a_clk;
  logic div_b_clk;

  scs_divider u_pre_a (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(pre_on(route.pre_a)), .i_tick(edge_a),
    .i_ratio(pre_ratio(route.pre_a)), .o_tick(pre_a_tick), .o_clk(pre_a_clk));
  scs_divider u_pre_b (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(pre_on(route.pre_b)), .i_tick(edge_b),
    .i_ratio(pre_ratio(route.pre_b)), .o_tick(pre_b_tick), .o_clk(pre_b_clk));

  // divider a runs from synth a pre-divider, divider b from synth b
  scs_divider u_div_a (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(div_a_code != 8'h00 && pre_on(route.pre_a)), .i_tick(pre_a_tick),
    .i_ratio(div_ratio(div_a_code)), .o_tick(div_a_tick), .o_clk(div_a_clk));
  scs_divider u_div_b (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(div_b_code != 8'h00 && pre_on(route.pre_b)), .i_tick(pre_b_tick),
    .i_ratio(div_ratio(div_b_code)), .o_tick(), .o_clk(div_b_clk));

  function automatic logic pin_val(input scs_pkg::scs_pin_sel_t s, input logic st);
    unique case (s)
      scs_pkg::SCS_PIN_DIV_A: pin_val = div_a_clk;
      scs_pkg::SCS_PIN_DIV_B: pin_val = div_b_clk;
      scs_pkg::SCS_PIN_STATUS: pin_val = st;
      scs_pkg::SCS_PIN_OFF: pin_val = 1'b0;
    endcase
  endfunction : pin_val

  logic next_pin_a;
  logic next_pin_b;
  logic next_oe_a_n;
  logic next_oe_b_n;
  always_comb begin
    next_pin_a = pin_val(route.pin_a, stat_a);
    next_pin_b = pin_val(route.pin_b, stat_b);
    next_oe_a_n = (route.pin_a == scs_pkg::SCS_PIN_OFF);
    next_oe_b_n = (route.pin_b == scs_pkg::SCS_PIN_OFF);
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_status_pin_a <= 1'b0;
      o_status_pin_b <= 1'b0;
      o_status_pin_a_oe_n <= 1'b0;
      o_status_pin_b_oe_n <= 1'b0;
      o_prescale_a_clk <= 1'b0;
      o_prescale_b_clk <= 1'b0;
    end else begin
      o_status_pin_a <= next_pin_a;
      o_status_pin_b <= next_pin_b;
      o_status_pin_a_oe_n <= next_oe_a_n;
      o_status_pin_b_oe_n <= next_oe_b_n;
      o_prescale_a_clk <= pre_a_clk;
      o_prescale_b_clk <= pre_b_clk;
    end
  end

  // assertions
  sequence s_pin_a_held(scs_pkg::scs_pin_sel_t sel);
    route.pin_a == sel ##1 route.pin_a == sel;
  endsequence
  sequence s_pin_b_held(scs_pkg::scs_pin_sel_t sel);
    route.pin_b == sel ##1 route.pin_b == sel;
  endsequence

  property p_reset_route;
    @(posedge i_clk) $rose(i_rst_n) |-> route == scs_pkg::scs_route_t'(`SCS_RESET_ROUTE_CTRL);
  endproperty
  a_reset_route: assert property (p_reset_route) else $error("route reset value wrong");

  property p_pin_a_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_pin_a_held(scs_pkg::SCS_PIN_OFF) |-> o_status_pin_a_oe_n && !o_status_pin_a;
  endproperty
  a_pin_a_off: assert property (p_pin_a_off) else $error("pin a not disabled");

  property p_pin_b_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_pin_b_held(scs_pkg::SCS_PIN_OFF) |-> o_status_pin_b_oe_n && !o_status_pin_b;
  endproperty
  a_pin_b_off: assert property (p_pin_b_off) else $error("pin b not disabled");

  property p_pin_a_diva;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_pin_a_held(scs_pkg::SCS_PIN_DIV_A) |-> o_status_pin_a == $past(div_a_clk);
  endproperty
  a_pin_a_diva: assert property (p_pin_a_diva) else $error("pin a not following divider a");

  property p_pre_a_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      route.pre_a == scs_pkg::SCS_PRE_OFF |-> ##1 !pre_a_clk;
  endproperty
  a_pre_a_off: assert property (p_pre_a_off) else $error("pre-divider a runs while off");

  property p_pre_b_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      route.pre_b == scs_pkg::SCS_PRE_RSVD |-> ##1 !pre_b_clk;
  endproperty
  a_pre_b_off: assert property (p_pre_b_off) else $error("pre-divider b runs on reserved code");

  property p_div_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      div_b_code == 8'h00 |-> ##1 !div_b_clk;
  endproperty
  a_div_off: assert property (p_div_off) else $error("divider b runs while off");

  property p_div_ratio;
    @(posedge i_clk) disable iff (!i_rst_n)
      div_a_tick |-> $past(u_div_a.cnt) >=
        (($past(div_a_code) <= `SCS_DIV_MIN_CODE) ? (`SCS_DIV_MIN_RATIO - 9'd1) : {1'b0, $past(div_a_code)});
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("divider ratio mapping wrong");

  property p_pre_b_src;
    @(posedge i_clk) disable iff (!i_rst_n)
      pre_b_tick |-> $past(edge_b) && pre_on($past(route.pre_b));
  endproperty
  a_pre_b_src: assert property (p_pre_b_src) else $error("pre-divider b tick without synth b edge");

  property p_pin_b_divb;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_pin_b_held(scs_pkg::SCS_PIN_DIV_B) |-> o_status_pin_b == $past(div_b_clk);
  endproperty
  a_pin_b_divb: assert property (p_pin_b_divb) else $error("pin b not following divider b");

  property p_pin_a_status;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_pin_a_held(scs_pkg::SCS_PIN_STATUS) |-> o_status_pin_a == $past(stat_a) && !o_status_pin_a_oe_n;
  endproperty
  a_pin_a_status: assert property (p_pin_a_status) else $error("pin a not carrying status");

  property p_pin_b_status;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_pin_b_held(scs_pkg::SCS_PIN_STATUS) |-> o_status_pin_b == $past(stat_b) && !o_status_pin_b_oe_n;
  endproperty
  a_pin_b_status: assert property (p_pin_b_status) else $error("pin b not carrying status");

  property p_answer_one;
    @(posedge i_clk) disable iff (!i_rst_n)
      !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_answer_one: assert property (p_answer_one) else $error("bus answer held longer than one cycle");
endmodule : scs_status_clock_select
